//--- sim/bdmd_decoder_test.sv
// Purpose: directed test of the banked data memory decoder
// Assumes: answer exactly two cycles after each request
// Notes: inputs change on the falling edge only
`timescale 1ns/1ps
module bdmd_decoder_test;
    reg ref_clk;
    reg rst_b = 1'b0;
    reg acc_req = 1'b0;
    reg acc_wr = 1'b0;
    reg [6:0] acc_offs = 7'h00;
    reg [7:0] acc_wdata = 8'h00;
    wire [7:0] acc_rdata;
    wire acc_done;
    wire p_sel;
    wire p_wr;
    wire [12:0] p_addr;
    wire [7:0] p_wdata;
    wire [7:0] p_rdata;
    wire [5:0] bsel;
    wire [7:0] work_o;
    wire [7:0] pcl_o;
    wire [7:0] stat_o;
    wire [7:0] plath_o;
    wire [7:0] intc_o;
    integer num_errors = 0;
    integer n_compared = 0;
    integer i;
    bdmd_decoder i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .acc_req(acc_req), .acc_wr(acc_wr),
        .acc_offs(acc_offs), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_done(acc_done),
        .special_function_reg_sel(p_sel), .special_function_reg_wr(p_wr),
        .special_function_reg_addr(p_addr), .special_function_reg_wdata(p_wdata),
        .special_function_reg_rdata(p_rdata), .program_counter_low(pcl_o), .status(stat_o),
        .bank_select_reg(bsel), .working_register(work_o), .program_counter_latch_high(plath_o),
        .interrupt_control(intc_o));
    bdmd_periph i_per (.ref_clk(ref_clk), .sel(p_sel), .wr(p_wr), .addr(p_addr),
        .wdata(p_wdata), .rdata(p_rdata));
    function [7:0] pexp(input [12:0] a);
        pexp = a[7:0] ^ 8'ha5;
    endfunction
    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task acc(input w, input [6:0] o, input [7:0] d);
        begin
            @(negedge ref_clk);
            acc_req = 1'b1;
            acc_wr = w;
            acc_offs = o;
            acc_wdata = d;
            @(negedge ref_clk);
            acc_req = 1'b0;
            // answer stands for one cycle only, in the cycle after this one
            @(negedge ref_clk);
            chk({7'h00, acc_done}, 8'h01);
        end
    endtask
    task wr(input [6:0] o, input [7:0] d);
        begin
            acc(1'b1, o, d);
            chk(acc_rdata, 8'h00);
        end
    endtask
    task rd(input [6:0] o, input [7:0] exp);
        begin
            acc(1'b0, o, 8'h00);
            chk(acc_rdata, exp);
        end
    endtask
    task sb(input [5:0] b);
        wr(7'h08, {2'b00, b});
    endtask
    // both ends of each peripheral window, short and long banks
    task per(input [5:0] b);
        reg [6:0] top;
        begin
            top = (b >= 6'h3c) ? 7'h6f : 7'h1f;
            sb(b);
            rd(7'h0c, pexp({b, 7'h0c}));
            rd(top, pexp({b, top}));
        end
    endtask
    task summarize;
        begin
            $display("compared %0d, mismatches %0d", n_compared, num_errors);
            if (num_errors == 0 && n_compared > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        #20000;
        num_errors = num_errors + 1;
        summarize;
    end
    initial begin
        repeat (6) @(negedge ref_clk);
        rst_b = 1'b1;
        for (i = 2; i < 12; i = i + 1) rd(i[6:0], 8'h00);
        $display("test reset done");
        for (i = 2; i < 12; i = i + 1) if (i < 4 || i > 8) wr(i[6:0], 8'h40 + i[7:0]);
        sb(6'h3e);
        for (i = 2; i < 12; i = i + 1) if (i < 4 || i > 8) rd(i[6:0], 8'h40 + i[7:0]);
        chk(work_o, 8'h49);
        chk(pcl_o, 8'h42);
        chk(stat_o, 8'h43);
        chk(plath_o, 8'h4a);
        chk(intc_o, 8'h4b);
        wr(7'h08, 8'hff);
        rd(7'h08, 8'h3f);
        chk({2'b00, bsel}, 8'h3f);
        $display("test core done");
        sb(6'h00);
        wr(7'h20, 8'h11);
        sb(6'h01);
        wr(7'h20, 8'h22);
        sb(6'h3b);
        wr(7'h6f, 8'h33);
        sb(6'h00);
        rd(7'h20, 8'h11);
        sb(6'h01);
        rd(7'h20, 8'h22);
        sb(6'h3b);
        rd(7'h6f, 8'h33);
        sb(6'h03);
        wr(7'h70, 8'h77);
        wr(7'h7f, 8'h7e);
        sb(6'h3e);
        rd(7'h70, 8'h77);
        rd(7'h7f, 8'h7e);
        $display("test ram done");
        per(6'h02);
        per(6'h3b);
        per(6'h3c);
        per(6'h3f);
        sb(6'h02);
        wr(7'h15, 8'h5c);
        chk(i_per.last_addr[7:0], 8'h15);
        chk({3'h0, i_per.last_addr[12:8]}, 8'h01);
        chk(i_per.last_data, 8'h5c);
        $display("test peripheral done");
        wr(7'h05, 8'h00);
        wr(7'h04, 8'ha0);
        rd(7'h00, 8'h22);
        wr(7'h05, 8'h1e);
        wr(7'h04, 8'h0c);
        rd(7'h00, pexp(13'h1e0c));
        wr(7'h00, 8'h6d);
        chk(i_per.last_addr[7:0], 8'h0c);
        chk({3'h0, i_per.last_addr[12:8]}, 8'h1e);
        chk(i_per.last_data, 8'h6d);
        wr(7'h05, 8'h00);
        wr(7'h04, 8'h00);
        rd(7'h00, 8'h00);
        wr(7'h04, 8'h09);
        rd(7'h00, 8'h49);
        wr(7'h07, 8'h20);
        wr(7'h06, 8'h50);
        rd(7'h01, 8'h22);
        wr(7'h06, 8'h51);
        wr(7'h01, 8'h99);
        sb(6'h01);
        rd(7'h21, 8'h99);
        wr(7'h07, 8'h32);
        wr(7'h06, 8'hbf);
        rd(7'h01, 8'h33);
        wr(7'h06, 8'hc0);
        rd(7'h01, 8'h00);
        wr(7'h07, 8'h40);
        rd(7'h01, 8'h00);
        $display("test indirect done");
        // mid-run reset must clear core registers and the answer path
        @(negedge ref_clk);
        rst_b = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst_b = 1'b1;
        chk(work_o, 8'h00);
        chk({2'b00, bsel}, 8'h00);
        chk(acc_rdata, 8'h00);
        chk({7'h00, acc_done}, 8'h00);
        rd(7'h06, 8'h00);
        $display("test second reset done");
        summarize;
    end
endmodule // bdmd_decoder_test

//--- sim/bdmd_periph.sv
// Purpose: peripheral register area seen by the decoder
// Assumes: read data needed in the select cycle
// Notes: read data while selected is a fixed function of the address
`timescale 1ns/1ps
module bdmd_periph (
    input wire ref_clk,
    input wire sel,
    input wire wr,
    input wire [12:0] addr,
    input wire [7:0] wdata,
    output reg [7:0] rdata
);
    reg [7:0] prev_r = 8'h00;
    reg [12:0] last_addr = 13'h0000;
    reg [7:0] last_data = 8'h00;
    // unselected: inverse of last value so stale data never matches
    always @* begin
        if (sel)
            rdata = addr[7:0] ^ 8'ha5;
        else
            rdata = ~prev_r;
    end
    always @(posedge ref_clk) begin
        prev_r <= rdata;
        if (sel && wr) begin
            last_addr <= addr;
            last_data <= wdata;
        end
    end
endmodule // bdmd_periph

//--- sim/bdmd_props.sv
// Purpose: port-level checks for the banked data memory decoder
// Assumes: one clock, synchronous active-low reset
// Notes: bound to bdmd_decoder below the module
`timescale 1ns/1ps
module bdmd_props (
    input wire ref_clk,
    input wire rst_b,
    input wire acc_req,
    input wire acc_wr,
    input wire [6:0] acc_offs,
    input wire [7:0] acc_wdata,
    input wire [7:0] acc_rdata,
    input wire acc_done,
    input wire special_function_reg_sel,
    input wire special_function_reg_wr,
    input wire [12:0] special_function_reg_addr,
    input wire [7:0] special_function_reg_rdata,
    input wire [5:0] bank_select_reg,
    input wire [7:0] working_register
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire long_b = bank_select_reg >= 6'h3c;
    wire dir_sfr = acc_req && acc_offs >= 7'h0c && acc_offs < (long_b ? 7'h70 : 7'h20);
    wire [6:0] s_off = special_function_reg_addr[6:0];
    wire s_long = special_function_reg_addr[12:7] >= 6'h3c;
    sequence s_answer; ##2 acc_done; endsequence
    sequence s_sfr_rd; special_function_reg_sel && !acc_wr; endsequence
    property p_done; acc_req |-> s_answer; endproperty
    property p_idle; !acc_req |-> ##2 !acc_done; endproperty
    property p_dir_sel;
        dir_sfr |-> special_function_reg_sel && special_function_reg_addr == {bank_select_reg, acc_offs};
    endproperty
    property p_core; acc_req && acc_offs > 7'h01 && acc_offs < 7'h0c |-> !special_function_reg_sel; endproperty
    property p_common; acc_req && acc_offs >= 7'h70 |-> !special_function_reg_sel; endproperty
    property p_sel_rng;
        special_function_reg_sel |-> acc_req && s_off >= 7'h0c && s_off < (s_long ? 7'h70 : 7'h20);
    endproperty
    property p_bank_wr;
        acc_req && acc_wr && acc_offs == 7'h08 |=> {2'b00, bank_select_reg} == ($past(acc_wdata) & 8'h3f);
    endproperty
    property p_work_wr; acc_req && acc_wr && acc_offs == 7'h09 |=> working_register == $past(acc_wdata); endproperty
    property p_wr_zero; acc_req && acc_wr |-> ##2 acc_done && acc_rdata == 8'h00; endproperty
    property p_sfr_data; s_sfr_rd |-> ##2 acc_rdata == $past(special_function_reg_rdata, 2); endproperty
    property p_wr_copy; special_function_reg_sel |-> special_function_reg_wr == acc_wr; endproperty
    a_done: assert property (p_done) else $error("no answer two cycles after request");
    a_idle: assert property (p_idle) else $error("answer without request");
    a_dir_sel: assert property (p_dir_sel) else $error("peripheral select or address wrong");
    a_core: assert property (p_core) else $error("core offset reached peripherals");
    a_common: assert property (p_common) else $error("common offset reached peripherals");
    a_sel_rng: assert property (p_sel_rng) else $error("select outside peripheral area");
    a_bank_wr: assert property (p_bank_wr) else $error("bank select not updated");
    a_work_wr: assert property (p_work_wr) else $error("working register not updated");
    a_wr_zero: assert property (p_wr_zero) else $error("write answer not zero");
    a_sfr_data: assert property (p_sfr_data) else $error("peripheral data not returned");
    a_wr_copy: assert property (p_wr_copy) else $error("peripheral write flag wrong");
endmodule // bdmd_props
bind bdmd_decoder bdmd_props i_props (.ref_clk(ref_clk), .rst_b(rst_b), .acc_req(acc_req),
    .acc_wr(acc_wr), .acc_offs(acc_offs), .acc_wdata(acc_wdata), .acc_rdata(acc_rdata),
    .acc_done(acc_done), .special_function_reg_sel(special_function_reg_sel),
    .special_function_reg_wr(special_function_reg_wr),
    .special_function_reg_addr(special_function_reg_addr),
    .special_function_reg_rdata(special_function_reg_rdata),
    .bank_select_reg(bank_select_reg), .working_register(working_register));

//--- verilog/bdmd_decoder.v
// Purpose: banked data memory decoder with core registers
// Assumes: core issues at most one access per cycle on ref_clk
// Notes: read data return two cycles after the request
`timescale 1ns/1ps
`include "bdmd_map.vh"

module bdmd_decoder (
    input wire ref_clk,
    input wire rst_b,
    input wire acc_req,
    input wire acc_wr,
    input wire [`BDMD_OFFS_W-1:0] acc_offs,
    input wire [7:0] acc_wdata,
    output wire [7:0] acc_rdata,
    output wire acc_done,
    output wire special_function_reg_sel,
    output wire special_function_reg_wr,
    output wire [`BDMD_ADDR_W-1:0] special_function_reg_addr,
    output wire [7:0] special_function_reg_wdata,
    input wire [7:0] special_function_reg_rdata,
    output wire [7:0] program_counter_low,
    output wire [7:0] status,
    output wire [`BDMD_BANK_W-1:0] bank_select_reg,
    output wire [7:0] working_register,
    output wire [7:0] program_counter_latch_high,
    output wire [7:0] interrupt_control
);
    localparam RG_NONE = 5'b00001;
    localparam RG_CORE = 5'b00010;
    localparam RG_SFR = 5'b00100;
    localparam RG_GPR = 5'b01000;
    localparam RG_COM = 5'b10000;

    reg [7:0] pcl_r;
    reg [7:0] status_r;
    reg [7:0] p0l_r;
    reg [7:0] p0h_r;
    reg [7:0] p1l_r;
    reg [7:0] p1h_r;
    reg [`BDMD_BANK_W-1:0] bsr_r;
    reg [7:0] working_register_r;
    reg [7:0] program_counter_latch_high_r;
    reg [7:0] interrupt_control_r;

    reg s1_vld_r;
    reg s1_rd_r;
    reg [4:0] s1_rg_r;
    reg [7:0] s1_core_r;
    reg [7:0] s1_sfr_r;
    reg [7:0] rdata_r;
    reg done_r;

    wire is_ind;
    wire [15:0] ptr;
    wire ptr_lin;
    wire ptr_bnk;
    wire [`BDMD_ADDR_W-1:0] eff_addr;
    wire [`BDMD_BANK_W-1:0] eff_bank;
    wire [`BDMD_OFFS_W-1:0] eff_offs;
    wire [4:0] bank_rg;
    reg [4:0] acc_rg;
    reg [`BDMD_RAM_AW-1:0] ram_addr;
    wire ram_en;
    wire ram_we;
    wire [7:0] ram_rdata;
    wire core_we;

    // peripheral area length depends on which group of banks
    function [4:0] region;
        input [`BDMD_BANK_W-1:0] bank;
        input [`BDMD_OFFS_W-1:0] offs;
        reg [`BDMD_OFFS_W-1:0] sfr_end;
        begin
            sfr_end = (bank < `BDMD_LONG_BANK) ?
                `BDMD_CORE_CNT + `BDMD_SFR_SHORT :
                `BDMD_CORE_CNT + `BDMD_SFR_LONG;
            if (offs < `BDMD_CORE_CNT) begin
                region = RG_CORE;
            end else if (offs < sfr_end) begin
                region = RG_SFR;
            end else if (offs >= `BDMD_COM_LO) begin
                region = RG_COM;
            end else if (bank < `BDMD_LONG_BANK) begin
                region = RG_GPR;
            end else begin
                region = RG_NONE;
            end
        end
    endfunction

    // packs the 80 gpr bytes of each bank below 0x3c back to back
    function [`BDMD_RAM_AW-1:0] gpr_phys;
        input [`BDMD_BANK_W-1:0] bank;
        input [`BDMD_OFFS_W-1:0] offs;
        begin
            gpr_phys = {7'h00, bank} * `BDMD_GPR_SIZE
                + {6'h00, offs} - {6'h00, `BDMD_GPR_LO};
        end
    endfunction

    // common bytes follow all banked gpr in the store
    function [`BDMD_RAM_AW-1:0] com_phys;
        input [`BDMD_OFFS_W-1:0] offs;
        begin
            com_phys = `BDMD_GPR_TOTAL
                + {6'h00, offs} - {6'h00, `BDMD_COM_LO};
        end
    endfunction

    function [7:0] core_rd;
        input [`BDMD_OFFS_W-1:0] offs;
        begin
            case (offs)
                `BDMD_OFF_PCL: core_rd = pcl_r;
                `BDMD_OFF_STATUS: core_rd = status_r;
                `BDMD_OFF_P0L: core_rd = p0l_r;
                `BDMD_OFF_P0H: core_rd = p0h_r;
                `BDMD_OFF_P1L: core_rd = p1l_r;
                `BDMD_OFF_P1H: core_rd = p1h_r;
                `BDMD_OFF_BSR: core_rd = {2'b00, bsr_r};
                `BDMD_OFF_WORKING_REGISTER: core_rd = working_register_r;
                `BDMD_OFF_PROGRAM_COUNTER_LATCH_HIGH: core_rd = program_counter_latch_high_r;
                `BDMD_OFF_INTERRUPT_CONTROL: core_rd = interrupt_control_r;
                default: core_rd = `BDMD_ZERO_BYTE;
            endcase
        end
    endfunction

    // offsets 0 and 1 are the indirect ports of pointer 0 and 1
    assign is_ind = (acc_offs == `BDMD_OFF_IND0) ||
        (acc_offs == `BDMD_OFF_IND1);
    assign ptr = acc_offs[0] ? {p1h_r, p1l_r} : {p0h_r, p0l_r};
    assign ptr_lin = (ptr[15:13] == `BDMD_PTR_LINEAR);
    assign ptr_bnk = (ptr[15:13] == `BDMD_PTR_BANKED);
    assign eff_addr = is_ind ? ptr[12:0] : {bsr_r, acc_offs};
    assign eff_bank = eff_addr[12:7];
    assign eff_offs = eff_addr[6:0];
    assign bank_rg = region(eff_bank, eff_offs);

    always @* begin
        acc_rg = RG_NONE;
        ram_addr = {`BDMD_RAM_AW{1'b0}};
        if (is_ind && ptr_lin) begin
            // linear index already equals the packed gpr index
            if (ptr[12:0] < `BDMD_GPR_TOTAL) begin
                acc_rg = RG_GPR;
                ram_addr = ptr[12:0];
            end
        end else if (!is_ind || ptr_bnk) begin
            acc_rg = bank_rg;
            // a pointer aimed at an indirect port reaches nothing
            if (is_ind && bank_rg == RG_CORE && eff_offs < `BDMD_OFF_P0L - 7'h02) begin
                acc_rg = RG_NONE;
            end
            if (bank_rg == RG_GPR) begin
                ram_addr = gpr_phys(eff_bank, eff_offs);
            end else if (bank_rg == RG_COM) begin
                ram_addr = com_phys(eff_offs);
            end
        end
    end

    assign ram_en = acc_req && (acc_rg == RG_GPR || acc_rg == RG_COM);
    assign ram_we = acc_wr;

    bdmd_ram u_ram (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .ram_en(ram_en),
        .ram_we(ram_we),
        .ram_addr(ram_addr),
        .ram_wdata(acc_wdata),
        .ram_rdata_r(ram_rdata)
    );

    // peripheral side is same-clock logic answering in the request cycle
    assign special_function_reg_sel = acc_req && (acc_rg == RG_SFR);
    assign special_function_reg_wr = acc_wr;
    assign special_function_reg_addr = eff_addr;
    assign special_function_reg_wdata = acc_wdata;

    assign core_we = acc_req && acc_wr && (acc_rg == RG_CORE);

    always @(posedge ref_clk) begin
        if (!rst_b) begin
            pcl_r <= `BDMD_RST_BYTE;
            status_r <= `BDMD_RST_BYTE;
            p0l_r <= `BDMD_RST_BYTE;
            p0h_r <= `BDMD_RST_BYTE;
            p1l_r <= `BDMD_RST_BYTE;
            p1h_r <= `BDMD_RST_BYTE;
            bsr_r <= `BDMD_RST_BANK;
            working_register_r <= `BDMD_RST_BYTE;
            program_counter_latch_high_r <= `BDMD_RST_BYTE;
            interrupt_control_r <= `BDMD_RST_BYTE;
        end else if (core_we) begin
            case (eff_offs)
                `BDMD_OFF_PCL: pcl_r <= acc_wdata;
                `BDMD_OFF_STATUS: status_r <= acc_wdata;
                `BDMD_OFF_P0L: p0l_r <= acc_wdata;
                `BDMD_OFF_P0H: p0h_r <= acc_wdata;
                `BDMD_OFF_P1L: p1l_r <= acc_wdata;
                `BDMD_OFF_P1H: p1h_r <= acc_wdata;
                `BDMD_OFF_BSR: bsr_r <= acc_wdata[5:0];
                `BDMD_OFF_WORKING_REGISTER: working_register_r <= acc_wdata;
                `BDMD_OFF_PROGRAM_COUNTER_LATCH_HIGH: program_counter_latch_high_r <= acc_wdata;
                `BDMD_OFF_INTERRUPT_CONTROL: interrupt_control_r <= acc_wdata;
                default: pcl_r <= pcl_r;
            endcase
        end
    end

    // stage one: ram read in flight, core and peripheral data captured
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            s1_vld_r <= 1'b0;
            s1_rd_r <= 1'b0;
            s1_rg_r <= RG_NONE;
            s1_core_r <= `BDMD_ZERO_BYTE;
            s1_sfr_r <= `BDMD_ZERO_BYTE;
        end else begin
            s1_vld_r <= acc_req;
            s1_rd_r <= acc_req && !acc_wr;
            s1_rg_r <= acc_rg;
            s1_core_r <= core_rd(eff_offs);
            s1_sfr_r <= special_function_reg_rdata;
        end
    end

    // stage two: answer leaves from a flop
    always @(posedge ref_clk) begin
        if (!rst_b) begin
            rdata_r <= `BDMD_ZERO_BYTE;
            done_r <= 1'b0;
        end else begin
            done_r <= s1_vld_r;
            if (!s1_rd_r) begin
                rdata_r <= `BDMD_ZERO_BYTE;
            end else begin
                case (s1_rg_r)
                    RG_CORE: rdata_r <= s1_core_r;
                    RG_SFR: rdata_r <= s1_sfr_r;
                    RG_GPR: rdata_r <= ram_rdata;
                    RG_COM: rdata_r <= ram_rdata;
                    default: rdata_r <= `BDMD_ZERO_BYTE;
                endcase
            end
        end
    end

    assign acc_rdata = rdata_r;
    assign acc_done = done_r;
    assign program_counter_low = pcl_r;
    assign status = status_r;
    assign bank_select_reg = bsr_r;
    assign working_register = working_register_r;
    assign program_counter_latch_high = program_counter_latch_high_r;
    assign interrupt_control = interrupt_control_r;
endmodule // bdmd_decoder

//--- verilog/bdmd_map.vh
// Purpose: constants for the banked data memory decoder
// Assumes: included by bare name from every design file
// Notes: offsets are within-bank offsets, counts are byte locations
`ifndef BDMD_MAP_VH
`define BDMD_MAP_VH
`define BDMD_ADDR_W 13
`define BDMD_BANK_W 6
`define BDMD_OFFS_W 7
`define BDMD_CORE_CNT 7'h0c
`define BDMD_SFR_SHORT 7'h14
`define BDMD_SFR_LONG 7'h64
`define BDMD_LONG_BANK 6'h3c
`define BDMD_GPR_LO 7'h20
`define BDMD_COM_LO 7'h70
`define BDMD_GPR_SIZE 13'h0050
`define BDMD_GPR_TOTAL 13'h12c0
`define BDMD_RAM_DEPTH 4816
`define BDMD_RAM_AW 13
`define BDMD_PTR_LINEAR 3'h1
`define BDMD_PTR_BANKED 3'h0
`define BDMD_OFF_IND0 7'h00
`define BDMD_OFF_IND1 7'h01
`define BDMD_OFF_PCL 7'h02
`define BDMD_OFF_STATUS 7'h03
`define BDMD_OFF_P0L 7'h04
`define BDMD_OFF_P0H 7'h05
`define BDMD_OFF_P1L 7'h06
`define BDMD_OFF_P1H 7'h07
`define BDMD_OFF_BSR 7'h08
`define BDMD_OFF_WORKING_REGISTER 7'h09
`define BDMD_OFF_PROGRAM_COUNTER_LATCH_HIGH 7'h0a
`define BDMD_OFF_INTERRUPT_CONTROL 7'h0b
`define BDMD_RST_BYTE 8'h00
`define BDMD_RST_BANK 6'h00
`define BDMD_ZERO_BYTE 8'h00
`endif

//--- verilog/bdmd_ram.v
// Purpose: physical byte store for banked and common data ram
// Assumes: one access per cycle, read data registered
// Notes: contents are not reset, like real sram
`timescale 1ns/1ps
`include "bdmd_map.vh"
module bdmd_ram (
    input wire ref_clk,
    input wire rst_b,
    input wire ram_en,
    input wire ram_we,
    input wire [`BDMD_RAM_AW-1:0] ram_addr,
    input wire [7:0] ram_wdata,
    output reg [7:0] ram_rdata_r
);
    reg [7:0] mem [0:`BDMD_RAM_DEPTH-1];

    always @(posedge ref_clk) begin
        if (ram_en && ram_we) begin
            mem[ram_addr] <= ram_wdata;
        end
    end

    always @(posedge ref_clk) begin
        if (!rst_b) begin
            ram_rdata_r <= `BDMD_ZERO_BYTE;
        end else if (ram_en && !ram_we) begin
            ram_rdata_r <= mem[ram_addr];
        end
    end
endmodule // bdmd_ram
